// File: core/dlce_pkg.sv
// Shared constants, address map and carrier types of the level DAC calibration engine
package dlce_pkg;
    // Geometry
    localparam int CHANNELS = 4;
    localparam int FUNCS = 5;
    localparam int SETS = 6;
    localparam int NDAC = CHANNELS * FUNCS;
    localparam int NENT = NDAC * SETS;
    localparam int RES = 16;
    // Function codes inside a channel
    localparam logic [2:0] FN_FORCE = 3'h0;
    localparam logic [2:0] FN_CMPHI = 3'h1;
    localparam logic [2:0] FN_CMPLO = 3'h2;
    localparam logic [2:0] FN_CLPHI = 3'h3;
    localparam logic [2:0] FN_CLPLO = 3'h4;
    // Mode codes: voltage, four internal ranges, external range
    localparam logic [2:0] MODE_VOLT = 3'h0;
    localparam logic [2:0] MODE_EXT = 3'h5;
    localparam logic [2:0] CLAMP_CUR_SET = 3'h1;
    // Reset values
    localparam logic [15:0] GAIN_RST = 16'hffff;
    localparam logic [15:0] OFFS_RST = 16'h8000;
    localparam logic [15:0] CODE_RST = 16'h0000;
    localparam logic [15:0] GOFFS_RST = 16'h0000;
    // Address map: bit 10 clear selects the per-DAC code space
    localparam int AW = 11;
    localparam int A_GLOBAL = 10;
    localparam int A_CH_LO = 8;
    localparam int A_FN_LO = 5;
    localparam int A_SET_LO = 2;
    localparam logic [1:0] FLD_INPUT = 2'h0;
    localparam logic [1:0] FLD_GAIN = 2'h1;
    localparam logic [1:0] FLD_OFFSET = 2'h2;
    localparam logic [1:0] FLD_CORR = 2'h3;
    localparam logic [AW-1:0] ADDR_GOFFS = 11'h400;
    localparam logic [AW-1:0] ADDR_MODE0 = 11'h401;
    localparam logic [AW-1:0] ADDR_STATUS = 11'h408;
    // Timing
    localparam int CLK_NS = 50;
    localparam int BUSY_BASE_NS = 250;
    localparam int BUSY_STEP_NS = 500;
    localparam int BUSY_BASE_CYC = (BUSY_BASE_NS + CLK_NS - 1) / CLK_NS;
    localparam int BUSY_STEP_CYC = (BUSY_STEP_NS + CLK_NS - 1) / CLK_NS;
    // Register port request
    typedef struct packed {
        logic [AW-1:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } dlce_req_s;
    // Work handed to the correction datapath
    typedef struct packed {
        logic [6:0] idx;
        logic [15:0] inputCode;
        logic [15:0] gain;
        logic [15:0] offs;
    } dlce_job_s;
endpackage : dlce_pkg

// File: core/dlce_corr_unit.sv
// Registered gain and offset correction datapath, one job per cycle
`timescale 1ns/1ps
module dlce_corr_unit
    import dlce_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Job in
    input wire logic jobValid,
    input dlce_job_s job,
    // Result out
    output logic resValid,
    output logic [6:0] resIdx,
    output logic [15:0] resCode
);
    // Full width product keeps every bit until the final shift
    logic [32:0] prod;
    logic signed [18:0] sum;
    logic [15:0] clipped;

    // Product, offset term and clip to the code range
    always_comb
    begin
        prod = ({1'b0, job.gain} + 17'h00001) * {17'h00000, job.inputCode};
        sum = $signed({2'b00, prod[32:RES]}) + $signed({3'b000, job.offs})
            - $signed({3'b000, OFFS_RST});
        if (sum < 0)
            clipped = 16'h0000;
        else if (sum > $signed({3'b000, 16'hffff}))
            clipped = 16'hffff;
        else
            clipped = sum[15:0];
    end

    // Result register
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            resValid <= 1'b0;
            resIdx <= 7'h00;
            resCode <= CODE_RST;
        end
        else
        begin
            resValid <= jobValid;
            resIdx <= job.idx;
            resCode <= clipped;
        end
    end

    a_corr_unity: assert property (@(posedge clk) disable iff (srst)
        jobValid && job.gain == GAIN_RST && job.offs == OFFS_RST
        |=> resCode == $past(job.inputCode))
        else $error("Default gain and offset did not pass the input code");
    a_corr_noclip: assert property (@(posedge clk) disable iff (srst)
        jobValid && job.offs == OFFS_RST |=> resCode <= $past(job.inputCode))
        else $error("Corrected code exceeded input with unity offset");
endmodule : dlce_corr_unit

// File: core/dlce_busy_timer.sv
// Busy pulse generator sized by the number of channels being updated
`timescale 1ns/1ps
module dlce_busy_timer
    import dlce_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Input code write and its channel
    input wire logic start,
    input wire logic [CHANNELS-1:0] chanHit,
    input wire logic engIdle,
    // Active low busy level
    output logic busyN
);
    logic running_r;
    logic [7:0] elapsed_r;
    logic [CHANNELS-1:0] chans_r;
    logic [7:0] target;

    // Length grows by one step for every channel touched in this pulse
    always_comb
    begin
        target = 8'(BUSY_BASE_CYC + BUSY_STEP_CYC * ($countones(chans_r) + 1));
    end

    // Pulse runs its full length and until every queued correction is done
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            running_r <= 1'b0;
            elapsed_r <= 8'h00;
            chans_r <= '0;
        end
        else if (start)
        begin
            running_r <= 1'b1;
            elapsed_r <= running_r ? elapsed_r + 8'h01 : 8'h00;
            chans_r <= (running_r ? chans_r : '0) | chanHit;
        end
        else if (running_r)
        begin
            if (elapsed_r >= target - 8'h01 && engIdle)
                running_r <= 1'b0;
            elapsed_r <= elapsed_r + 8'h01;
        end
    end

    assign busyN = !running_r;

    a_busy_length: assert property (@(posedge clk) disable iff (srst)
        running_r && elapsed_r < target - 8'h01 && !start |=> running_r)
        else $error("Busy ended before its minimum length");
endmodule : dlce_busy_timer

// File: core/dac_level_calibration_engine.sv
// Level DAC input, gain, offset and cached corrected codes with mode-driven output update
//
// The address map and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
module dac_level_calibration_engine
    import dlce_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Register port
    input dlce_req_s busReq,
    output logic [15:0] rdata,
    // Update strobe and busy
    input wire logic loadN,
    output logic busyN,
    // Analog side codes
    output logic [NDAC-1:0][15:0] dacCode,
    output logic [15:0] globalOffset,
    output logic [CHANNELS-1:0][2:0] activeMode
);
    // Code storage, one entry per DAC and set
    logic [15:0] inCode_r [NENT];
    logic [15:0] gain_r [NENT];
    logic [15:0] offs_r [NENT];
    logic [15:0] corr_r [NENT];
    logic [NENT-1:0] pend_r;
    logic [CHANNELS-1:0][2:0] modeShadow_r;
    logic loadReq_r;
    logic inFlight_r;
    logic [15:0] rdata_r;

    // Decoded request
    logic dacSpace;
    logic [1:0] aChan;
    logic [2:0] aFunc;
    logic [2:0] aSet;
    logic [1:0] aField;
    logic aValid;
    logic [6:0] aIdx;
    logic inWrite;
    logic applyNow;
    logic pickFound;
    logic [6:0] pickIdx;
    dlce_job_s job;
    logic resValid;
    logic [6:0] resIdx;
    logic [15:0] resCode;

    // Flat entry index of a DAC set
    function automatic logic [6:0] entryIdx(input logic [1:0] ch, input logic [2:0] fn,
                                            input logic [2:0] st);
        entryIdx = 7'(ch * FUNCS * SETS + fn * SETS + st);
    endfunction : entryIdx

    // Set that a mode selects; clamps share one set among all current ranges
    function automatic logic [2:0] setOfMode(input logic [2:0] fn, input logic [2:0] md);
        if (fn == FN_CLPHI || fn == FN_CLPLO)
            setOfMode = (md == MODE_VOLT) ? MODE_VOLT : CLAMP_CUR_SET;
        else if (md > MODE_EXT)
            setOfMode = MODE_EXT;
        else
            setOfMode = md;
    endfunction : setOfMode

    // Whether a set number exists for a function
    function automatic logic setExists(input logic [2:0] fn, input logic [2:0] st);
        if (fn > FN_CLPLO)
            setExists = 1'b0;
        else if (fn == FN_CLPHI || fn == FN_CLPLO)
            setExists = (st <= CLAMP_CUR_SET);
        else
            setExists = (st <= MODE_EXT);
    endfunction : setExists

    // Lowest pending entry, served one at a time through the single multiplier
    function automatic logic [7:0] firstPend(input logic [NENT-1:0] p);
        firstPend = 8'h00;
        for (int i = NENT - 1; i >= 0; i--)
            if (p[i])
                firstPend = {1'b1, 7'(i)};
    endfunction : firstPend

    // Address decode
    always_comb
    begin
        dacSpace = !busReq.addr[A_GLOBAL];
        aChan = busReq.addr[A_CH_LO +: 2];
        aFunc = busReq.addr[A_FN_LO +: 3];
        aSet = busReq.addr[A_SET_LO +: 3];
        aField = busReq.addr[A_SET_LO-1:0];
        aValid = dacSpace && setExists(aFunc, aSet);
        aIdx = entryIdx(aChan, aFunc, aSet);
        inWrite = busReq.wr && aValid && aField == FLD_INPUT;
        applyNow = loadReq_r && busyN;
        {pickFound, pickIdx} = firstPend(pend_r);
    end

    // Job for the correction datapath
    always_comb
    begin
        job.idx = pickIdx;
        job.inputCode = inCode_r[pickIdx];
        job.gain = gain_r[pickIdx];
        job.offs = offs_r[pickIdx];
    end

    // Input, gain and offset stores; gain and offset writes queue no work
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            for (int i = 0; i < NENT; i++)
            begin
                inCode_r[i] <= CODE_RST;
                gain_r[i] <= GAIN_RST;
                offs_r[i] <= OFFS_RST;
            end
        end
        else if (busReq.wr && aValid)
        begin
            case (aField)
                FLD_INPUT: inCode_r[aIdx] <= busReq.wdata;
                FLD_GAIN: gain_r[aIdx] <= busReq.wdata;
                FLD_OFFSET: offs_r[aIdx] <= busReq.wdata;
                default: ;
            endcase
        end
    end

    // Pending work; a new input write wins over the pick that clears it
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            pend_r <= '0;
            inFlight_r <= 1'b0;
        end
        else
        begin
            for (int i = 0; i < NENT; i++)
                if ((inWrite && aIdx == 7'(i)) || !(pickFound && pickIdx == 7'(i)))
                    pend_r[i] <= pend_r[i] || (inWrite && aIdx == 7'(i));
                else
                    pend_r[i] <= 1'b0;
            inFlight_r <= pickFound;
        end
    end

    // Sequential correction through one shared multiplier
    dlce_corr_unit u_corr (
        .clk(clk),
        .srst(srst),
        .jobValid(pickFound),
        .job(job),
        .resValid(resValid),
        .resIdx(resIdx),
        .resCode(resCode)
    );

    // Cached corrected codes, held until their mode is loaded
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            for (int i = 0; i < NENT; i++)
                corr_r[i] <= CODE_RST;
        end
        else if (resValid)
            corr_r[resIdx] <= resCode;
    end

    // Busy spans the write, the queue and the documented pulse length
    dlce_busy_timer u_busy (
        .clk(clk),
        .srst(srst),
        .start(inWrite),
        .chanHit(CHANNELS'(1) << aChan),
        .engIdle(!pickFound && !inFlight_r && !resValid),
        .busyN(busyN)
    );

    // Load request is latched so a strobe during busy is not lost
    always_ff @(posedge clk)
    begin
        if (srst)
            loadReq_r <= 1'b0;
        else if (!loadN)
            loadReq_r <= 1'b1;
        else if (applyNow)
            loadReq_r <= 1'b0;
    end

    // Mode shadows and the single global offset code
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            modeShadow_r <= '0;
            globalOffset <= GOFFS_RST;
        end
        else if (busReq.wr && !dacSpace)
        begin
            if (busReq.addr == ADDR_GOFFS)
                globalOffset <= busReq.wdata;
            for (int c = 0; c < CHANNELS; c++)
                if (busReq.addr == ADDR_MODE0 + AW'(c))
                    modeShadow_r[c] <= busReq.wdata[2:0];
        end
    end

    // Active mode follows the shadow only on a load outside busy
    always_ff @(posedge clk)
    begin
        if (srst)
            activeMode <= '0;
        else if (applyNow)
            activeMode <= modeShadow_r;
    end

    // Each DAC output picks the cached code of its new mode on load
    for (genvar d = 0; d < NDAC; d++)
    begin : g_dac
        localparam logic [1:0] DCH = 2'(d / FUNCS);
        localparam logic [2:0] DFN = 3'(d % FUNCS);
        always_ff @(posedge clk)
        begin
            if (srst)
                dacCode[d] <= CODE_RST;
            else if (applyNow)
                dacCode[d] <= corr_r[entryIdx(DCH, DFN,
                                              setOfMode(DFN, modeShadow_r[DCH]))];
        end
    end

    // Read data, one cycle after the strobe; unmapped reads give zero
    always_ff @(posedge clk)
    begin
        if (srst)
            rdata_r <= 16'h0000;
        else if (busReq.rd)
        begin
            rdata_r <= 16'h0000;
            if (aValid)
            begin
                case (aField)
                    FLD_INPUT: rdata_r <= inCode_r[aIdx];
                    FLD_GAIN: rdata_r <= gain_r[aIdx];
                    FLD_OFFSET: rdata_r <= offs_r[aIdx];
                    FLD_CORR: rdata_r <= corr_r[aIdx];
                    default: rdata_r <= 16'h0000;
                endcase
            end
            else if (busReq.addr == ADDR_GOFFS)
                rdata_r <= globalOffset;
            else if (busReq.addr == ADDR_STATUS)
                rdata_r <= {14'h0000, loadReq_r, busyN};
            else
            begin
                for (int c = 0; c < CHANNELS; c++)
                    if (busReq.addr == ADDR_MODE0 + AW'(c))
                        rdata_r <= {13'h0000, modeShadow_r[c]};
            end
        end
    end

    assign rdata = rdata_r;

    a_gain_reset: assert property (@(posedge clk)
        $past(srst) |-> gain_r[0] == GAIN_RST && gain_r[NENT-1] == GAIN_RST)
        else $error("Gain code not all ones after reset");
    a_offs_reset: assert property (@(posedge clk)
        $past(srst) |-> offs_r[0] == OFFS_RST && offs_r[NENT-1] == OFFS_RST)
        else $error("Offset code not midpoint after reset");
    a_busy_on_write: assert property (@(posedge clk) disable iff (srst)
        inWrite |=> !busyN)
        else $error("Busy not asserted after an input code write");
    a_gain_no_calc: assert property (@(posedge clk) disable iff (srst)
        busReq.wr && aField != FLD_INPUT && pend_r == '0 && !inWrite |=> pend_r == '0)
        else $error("Gain or offset write queued a recalculation");
    a_no_update_busy: assert property (@(posedge clk) disable iff (srst)
        !busyN ##1 !$past(applyNow) |-> $stable(dacCode) && $stable(activeMode))
        else $error("Output changed while busy");
    a_load_held: assert property (@(posedge clk) disable iff (srst)
        !loadN && !busyN |=> loadReq_r)
        else $error("Load during busy was not remembered");
    a_load_apply: assert property (@(posedge clk) disable iff (srst)
        applyNow |=> activeMode == $past(modeShadow_r) && !$past(loadN) == loadReq_r)
        else $error("Remembered load was not applied when busy rose");
    a_offset_write: assert property (@(posedge clk) disable iff (srst)
        busReq.wr && busReq.addr == ADDR_GOFFS |=> globalOffset == $past(busReq.wdata))
        else $error("Global offset code not taken");
    a_calc_done: assert property (@(posedge clk) disable iff (srst)
        inWrite && pend_r == '0 && !inFlight_r |-> ##[1:3] resValid)
        else $error("Corrected code not computed in time");

    // Input write stays queued even when a pick clears the same entry
    a_pend_on_write: assert property (@(posedge clk) disable iff (srst)
        inWrite |=> pend_r[$past(aIdx)])
        else $error("Input code write did not queue a correction");
    // Cache takes every result of the shared datapath
    a_cache_store: assert property (@(posedge clk) disable iff (srst)
        resValid |=> corr_r[$past(resIdx)] == $past(resCode))
        else $error("Corrected code not stored in its cache entry");
    // Modes move only on an applied load
    a_mode_hold: assert property (@(posedge clk) disable iff (srst)
        !applyNow |=> $stable(activeMode))
        else $error("Active mode changed without a load");
    // Cached codes reach the DACs only on an applied load
    a_dac_hold: assert property (@(posedge clk) disable iff (srst)
        !applyNow |=> $stable(dacCode))
        else $error("DAC code changed without a load");
    // Pending load survives the whole busy time
    a_load_wait: assert property (@(posedge clk) disable iff (srst)
        loadReq_r && !busyN |=> loadReq_r)
        else $error("Pending load dropped while busy");
    // Busy never shorter than the one channel pulse
    a_busy_min: assert property (@(posedge clk) disable iff (srst)
        inWrite && busyN |-> ##25 !busyN)
        else $error("Busy released before its one channel length");
    // Global offset reads back one cycle after the strobe
    a_goffs_read: assert property (@(posedge clk) disable iff (srst)
        busReq.rd && busReq.addr == ADDR_GOFFS |=> rdata == $past(globalOffset))
        else $error("Global offset read back wrong");
    // Status shows the pending load and the busy level
    a_status_read: assert property (@(posedge clk) disable iff (srst)
        busReq.rd && busReq.addr == ADDR_STATUS
        |=> rdata == {14'h0000, $past(loadReq_r), $past(busyN)})
        else $error("Status read back wrong");
endmodule : dac_level_calibration_engine

// File: sim/dlce_host_model.sv
// Host side register master and update strobe driver for the calibration engine
`timescale 1ns/1ps
module dlce_host_model
    import dlce_pkg::*;
(
    // Clock
    input wire logic clk,
    // Register port
    output dlce_req_s busReq,
    input wire logic [15:0] rdata,
    // Update strobe
    output logic loadN
);
    // Bus idle and strobe released until the bench asks for a transfer
    initial
    begin
        busReq = '0;
        loadN = 1'b1;
    end

    // One-cycle write; the bench picks codes for the wanted range
    task automatic wr(input logic [AW-1:0] a, input logic [15:0] d);
        @(posedge clk);
        busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        busReq <= '0;
    endtask : wr

    // One-cycle read; data only valid in the following cycle
    task automatic rd(input logic [AW-1:0] a, output logic [15:0] d);
        @(posedge clk);
        busReq <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        busReq <= '0;
        #1;
        d = rdata;
    endtask : rd

    // Short low pulse on the update strobe
    task automatic pulse();
        @(posedge clk);
        loadN <= 1'b0;
        @(posedge clk);
        loadN <= 1'b1;
    endtask : pulse

    // Strobe held at a level, e.g. permanently low
    task automatic hold(input logic v);
        @(posedge clk);
        loadN <= v;
    endtask : hold
endmodule : dlce_host_model

// File: sim/tb.sv
// Self-checking bench for the level DAC calibration engine
`timescale 1ns/1ps
module tb;
    import dlce_pkg::*;
    logic clk;
    logic srst;
    dlce_req_s busReq;
    logic [15:0] rdata;
    logic loadN;
    logic busyN;
    logic [NDAC-1:0][15:0] dacCode;
    logic [15:0] globalOffset;
    logic [CHANNELS-1:0][2:0] activeMode;
    int n_mismatch;
    int n_compared;
    integer seed;
    logic [15:0] cc [CHANNELS][FUNCS][SETS];
    logic [15:0] dexp [NDAC];
    int am [CHANNELS];

    // Design and host
    dac_level_calibration_engine dac_level_calibration_engine_inst (.clk(clk), .srst(srst),
        .busReq(busReq), .rdata(rdata), .loadN(loadN), .busyN(busyN), .dacCode(dacCode),
        .globalOffset(globalOffset), .activeMode(activeMode));
    dlce_host_model dlce_host_model_inst (.clk(clk), .busReq(busReq), .rdata(rdata),
        .loadN(loadN));

    // 20 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic conclude();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : conclude

    function automatic logic [AW-1:0] ad(input int c, f, s, input logic [1:0] fl);
        return {1'b0, 2'(c), 3'(f), 3'(s), fl};
    endfunction : ad

    // Expected corrected code, clipped rather than wrapped
    function automatic logic [15:0] corr(input logic [15:0] g, o, x);
        longint v;
        v = (((longint'(g) + 1) * longint'(x)) >>> 16) + longint'(o) - 32768;
        if (v < 0) v = 0;
        if (v > 65535) v = 65535;
        return 16'(v);
    endfunction : corr

    // Clamps share one set across current ranges; modes past external act as external
    function automatic int setOf(input int f, m);
        return (f >= 3) ? int'(m != 0) : ((m > int'(MODE_EXT)) ? int'(MODE_EXT) : m);
    endfunction : setOf

    task automatic wait_idle(output int k);
        k = 0;
        #1;
        while (busyN !== 1'b1 && k < 300)
        begin
            @(posedge clk);
            #1;
            k++;
        end
        if (k >= 300) n_mismatch++;
    endtask : wait_idle

    // Full code set per entry, as after power up
    task automatic prog(input int c, f, s, input logic [15:0] g, o, x);
        logic [15:0] v;
        int k;
        dlce_host_model_inst.wr(ad(c, f, s, FLD_GAIN), g);
        dlce_host_model_inst.wr(ad(c, f, s, FLD_OFFSET), o);
        #1;
        chk("busy gain", {15'h0, busyN}, 16'h0001);
        dlce_host_model_inst.wr(ad(c, f, s, FLD_INPUT), x);
        #1;
        chk("busy input", {15'h0, busyN}, 16'h0000);
        chk("dac in busy", dacCode[c*FUNCS+f], dexp[c*FUNCS+f]);
        wait_idle(k);
        chk("busy width", 16'(k), 16'(BUSY_BASE_CYC + 2 * BUSY_STEP_CYC));
        cc[c][f][s] = corr(g, o, x);
        dlce_host_model_inst.rd(ad(c, f, s, FLD_CORR), v);
        chk("cached", v, cc[c][f][s]);
    endtask : prog

    // Hang guard
    initial
    begin
        #(50 * 20000);
        n_mismatch++;
        conclude();
    end

    // Main sequence
    initial
    begin
        logic [15:0] v;
        int c;
        int f;
        int s;
        int n;
        n_mismatch = 0;
        n_compared = 0;
        seed = 32'h50155c9d;
        srst = 1'b1;
        foreach (cc[i, j, k]) cc[i][j][k] = CODE_RST;
        foreach (dexp[i]) dexp[i] = CODE_RST;
        foreach (am[i]) am[i] = 0;
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        for (int i = 0; i < 6; i++)
        begin
            c = $unsigned($random(seed)) % CHANNELS;
            f = $unsigned($random(seed)) % FUNCS;
            dlce_host_model_inst.rd(ad(c, f, i % 2, FLD_GAIN), v);
            chk("gain rst", v, GAIN_RST);
            dlce_host_model_inst.rd(ad(c, f, i % 2, FLD_OFFSET), v);
            chk("offs rst", v, OFFS_RST);
        end
        chk("dac rst", dacCode[NDAC-1], CODE_RST);
        // Two channels in one pulse; second write lands two cycles into it
        dlce_host_model_inst.wr(ad(0, 1, 4, FLD_INPUT), 16'h1357);
        dlce_host_model_inst.wr(ad(3, 2, 3, FLD_INPUT), 16'h2468);
        wait_idle(n);
        chk("busy two", 16'(n), 16'(BUSY_BASE_CYC + 3 * BUSY_STEP_CYC - 2));
        cc[0][1][4] = corr(GAIN_RST, OFFS_RST, 16'h1357);
        cc[3][2][3] = corr(GAIN_RST, OFFS_RST, 16'h2468);
        dlce_host_model_inst.rd(ad(0, 1, 4, FLD_CORR), v);
        chk("cached two", v, cc[0][1][4]);
        // Corners: quarter gain, both clip limits, last set of force and compare
        prog(0, 0, 5, 16'h4000, 16'h8000, 16'hffff);
        prog(1, 0, 4, 16'hffff, 16'hffff, 16'hffff);
        prog(2, 1, 5, 16'h0000, 16'h0000, 16'h0000);
        prog(3, 4, 1, 16'h8000, 16'h7000, 16'h1234);
        for (int i = 0; i < 14; i++)
        begin
            c = $unsigned($random(seed)) % CHANNELS;
            f = $unsigned($random(seed)) % FUNCS;
            s = (f >= 3) ? $unsigned($random(seed)) % 2 : $unsigned($random(seed)) % SETS;
            prog(c, f, s, 16'($random(seed)), 16'($random(seed)), 16'($random(seed)));
        end
        // Gain and offset alone leave the cached code alone
        dlce_host_model_inst.wr(ad(c, f, s, FLD_GAIN), 16'h1111);
        dlce_host_model_inst.wr(ad(c, f, s, FLD_OFFSET), 16'h2222);
        dlce_host_model_inst.rd(ad(c, f, s, FLD_CORR), v);
        chk("no recalc", v, cc[c][f][s]);
        // Every mode selected once; shadow waits for the strobe
        for (int m = 0; m < 8; m++)
        begin
            c = m % CHANNELS;
            dlce_host_model_inst.wr(ADDR_MODE0 + AW'(c), 16'(m));
            #1;
            chk("mode held", 16'(activeMode[c]), 16'(am[c]));
            dlce_host_model_inst.pulse();
            repeat (2) @(posedge clk);
            #1;
            am[c] = m;
            chk("mode", 16'(activeMode[c]), 16'(m));
            for (int k = 0; k < FUNCS; k++)
            begin
                dexp[c*FUNCS+k] = cc[c][k][setOf(k, m)];
                chk("dac", dacCode[c*FUNCS+k], dexp[c*FUNCS+k]);
            end
        end
        // Active set rewritten with the strobe held low
        dlce_host_model_inst.hold(1'b0);
        s = setOf(0, am[1]);
        prog(1, 0, s, 16'hfff0, 16'h8100, 16'($random(seed)));
        dexp[FUNCS] = cc[1][0][s];
        chk("dac live", dacCode[FUNCS], dexp[FUNCS]);
        dlce_host_model_inst.hold(1'b1);
        // Global offset takes effect without the strobe
        dlce_host_model_inst.wr(ADDR_GOFFS, 16'ha492);
        #1;
        chk("goffs", globalOffset, 16'ha492);
        dlce_host_model_inst.rd(11'h7ff, v);
        chk("unmapped", v, 16'h0000);
        repeat (3) @(posedge clk);
        dlce_host_model_inst.rd(ADDR_STATUS, v);
        chk("status", v, 16'h0001);
        conclude();
    end
endmodule : tb
